//--- rtl/fieldbus_pkg.sv
// constants, carrier types and states of the fieldbus write/diagnosis handler
// assumes framing and crc are checked upstream; bytes arrive one per strobe
`default_nettype none

package fieldbus_pkg;
	// -----------------------------------------------------------------
	// function and exception codes
	// -----------------------------------------------------------------
	localparam logic [7:0] FN_DIAG         = 8'h08;
	localparam logic [7:0] FN_DIAG_ERR     = 8'h88;
	localparam logic [7:0] FN_WR_SAVE      = 8'h06;
	localparam logic [7:0] FN_WR_SAVE_ERR  = 8'h86;
	localparam logic [7:0] FN_WR_RAM       = 8'h41;
	localparam logic [7:0] FN_WR_RAM_ERR   = 8'hc1;
	localparam logic [7:0] FN_WR_MULTI     = 8'h42;
	localparam logic [7:0] FN_WR_MULTI_ERR = 8'hc2;
	localparam logic [7:0] FN_ERR_FLAG     = 8'h80;
	localparam logic [7:0] EXC_ILL_FN      = 8'h01;
	localparam logic [7:0] EXC_ILL_ADDR    = 8'h02;
	localparam logic [7:0] EXC_ILL_VALUE   = 8'h03;
	localparam logic [7:0] EXC_LOCKED      = 8'h01;
	localparam logic [15:0] SUB_ECHO       = 16'h0000;
	// -----------------------------------------------------------------
	// frame layout
	// -----------------------------------------------------------------
	localparam logic [15:0] MAX_REGS       = 16'h0010;
	localparam logic [5:0] LEN_SINGLE      = 6'h05;
	localparam logic [5:0] LEN_MULTI_HDR   = 6'h06;
	localparam logic [5:0] REQ_MAX         = 6'h26;
	localparam logic [5:0] BASE_SINGLE     = 6'h03;
	localparam logic [5:0] BASE_MULTI      = 6'h06;
	localparam logic [2:0] LEN_NORMAL      = 3'h5;
	localparam logic [2:0] LEN_EXC         = 3'h2;
	localparam int         REQ_BYTES       = 38;
	localparam int         RESP_BYTES      = 5;
	// -----------------------------------------------------------------
	// parameter address space
	// -----------------------------------------------------------------
	localparam int         GRP_W           = 3;
	localparam int         IDX_W           = 4;
	localparam int         PIDX_W          = GRP_W + IDX_W;
	localparam int         DEPTH           = 1 << PIDX_W;
	localparam logic [7:0] NUM_GROUPS      = 8'h08;
	localparam logic [7:0] GROUP_SIZE      = 8'h10;
	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int CLK_HZ      = 40_000_000;
	localparam int NV_WRITE_US = 10;
	localparam int NV_WRITE_CYC = (NV_WRITE_US * CLK_HZ + 999_999) / 1_000_000;
	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [PIDX_W-1:0] idx;
		logic [15:0]       data;
		logic              save;
	} wr_req_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_EXEC  = 6'h02,
		ST_CHECK = 6'h04,
		ST_WRITE = 6'h08,
		ST_WAIT  = 6'h10,
		ST_TX    = 6'h20
	} state_t;
endpackage

`default_nettype wire

//--- rtl/param_store.sv
// parameter store: working RAM copy, nonvolatile copy and lock attributes
// assumes one write request at a time, issued only while o_busy is low
`default_nettype none

module param_store #(
	parameter logic [fieldbus_pkg::DEPTH-1:0] LOCK_MAP = '0,
	parameter int NV_CYC = fieldbus_pkg::NV_WRITE_CYC
) (
	// clock and reset
	input  wire logic                            i_sys_clk,
	input  wire logic                            i_sys_rst,
	// write port
	input  wire logic                            i_wr_en,
	input  wire fieldbus_pkg::wr_req_t           i_wr,
	// lock attribute lookup
	input  wire logic [fieldbus_pkg::PIDX_W-1:0] i_lock_idx,
	output logic                                 o_locked,
	// application read port
	input  wire logic [fieldbus_pkg::PIDX_W-1:0] i_app_idx,
	output logic [15:0]                          o_app_value,
	// status
	output logic                                 o_busy,
	output logic                                 o_ready
);
	// -----------------------------------------------------------------
	// storage
	// -----------------------------------------------------------------
	// nv is deliberately not reset: it models storage that survives power
	logic [15:0]                    ram [fieldbus_pkg::DEPTH];
	logic [15:0]                    nv  [fieldbus_pkg::DEPTH];
	logic [fieldbus_pkg::DEPTH-1:0] lock;
	logic [fieldbus_pkg::PIDX_W-1:0] rest_idx;
	logic [fieldbus_pkg::PIDX_W-1:0] next_rest_idx;
	logic                           restoring;
	logic                           next_restoring;
	logic [15:0]                    busy_cnt;
	logic [15:0]                    next_busy_cnt;

	assign o_locked = lock[i_lock_idx];

	// -----------------------------------------------------------------
	// restore sequence and save timer
	// -----------------------------------------------------------------
	always_comb begin
		next_rest_idx  = rest_idx;
		next_restoring = restoring;
		next_busy_cnt  = busy_cnt;
		if (restoring) begin
			next_rest_idx = rest_idx + 1'b1;
			if (&rest_idx)
				next_restoring = 1'b0;
		end else if (i_wr_en && i_wr.save) begin
			next_busy_cnt = 16'(NV_CYC);
		end else if (busy_cnt != 16'h0000) begin
			next_busy_cnt = busy_cnt - 16'h0001;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rest_idx  <= '0;
			restoring <= 1'b1;
			busy_cnt  <= 16'h0000;
			lock      <= LOCK_MAP;
			o_busy    <= 1'b1;
			o_ready   <= 1'b0;
		end else begin
			rest_idx  <= next_rest_idx;
			restoring <= next_restoring;
			busy_cnt  <= next_busy_cnt;
			o_busy    <= next_restoring || (next_busy_cnt != 16'h0000);
			o_ready   <= !next_restoring;
		end
	end

	// -----------------------------------------------------------------
	// memories
	// -----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (restoring)
			ram[rest_idx] <= nv[rest_idx];
		else if (i_wr_en)
			ram[i_wr.idx] <= i_wr.data;
		if (!restoring && i_wr_en && i_wr.save)
			nv[i_wr.idx] <= i_wr.data;
		o_app_value <= ram[i_app_idx];
	end

	save_busy_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(!restoring && i_wr_en && i_wr.save) |=> o_busy [*8])
		else $error("save did not hold busy");
endmodule // param_store

`default_nettype wire

//--- rtl/fieldbus_handler.sv
// request handler for diagnosis echo and single/multi parameter writes
// assumes rx bytes of one checked frame, i_rx_last on the final byte
`default_nettype none

module fieldbus_handler #(
	parameter logic [fieldbus_pkg::DEPTH-1:0] LOCK_MAP = '0,
	parameter int NV_CYC = fieldbus_pkg::NV_WRITE_CYC
) (
	// clock and reset
	input  wire logic                            i_sys_clk,
	input  wire logic                            i_sys_rst,
	// request bytes
	input  wire logic                            i_rx_valid,
	input  wire logic [7:0]                      i_rx_data,
	input  wire logic                            i_rx_last,
	output logic                                 o_rx_ready,
	// response bytes
	output logic                                 o_tx_valid,
	output logic [7:0]                           o_tx_data,
	output logic                                 o_tx_last,
	input  wire logic                            i_tx_ready,
	// drive state and application access
	input  wire logic                            i_running,
	input  wire logic [fieldbus_pkg::PIDX_W-1:0] i_app_idx,
	output logic [15:0]                          o_app_value
);
	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	fieldbus_pkg::state_t state;
	fieldbus_pkg::state_t next_state;
	logic [7:0]  req [fieldbus_pkg::REQ_BYTES];
	logic [7:0]  next_req [fieldbus_pkg::REQ_BYTES];
	logic [7:0]  resp [fieldbus_pkg::RESP_BYTES];
	logic [7:0]  next_resp [fieldbus_pkg::RESP_BYTES];
	logic [5:0]  cnt;
	logic [5:0]  next_cnt;
	logic        ovf;
	logic        next_ovf;
	logic [2:0]  resp_len;
	logic [2:0]  next_resp_len;
	logic [2:0]  tx_ptr;
	logic [2:0]  next_tx_ptr;
	logic [7:0]  err_fn;
	logic [7:0]  next_err_fn;
	logic [4:0]  num;
	logic [4:0]  next_num;
	logic [4:0]  k;
	logic [4:0]  next_k;
	logic [5:0]  base;
	logic [5:0]  next_base;
	logic        save;
	logic        next_save;
	logic        next_rx_ready;
	logic        next_tx_valid;
	logic [7:0]  next_tx_data;
	logic        next_tx_last;

	// -----------------------------------------------------------------
	// decode helpers
	// -----------------------------------------------------------------
	logic [15:0] f_addr;
	logic [15:0] f_word2;
	logic [15:0] cur_addr;
	logic [5:0]  pos;
	logic        addr_ok;
	logic        st_locked;
	logic        st_busy;
	logic        st_ready;
	logic        wr_en;
	fieldbus_pkg::wr_req_t wr;

	assign f_addr   = {req[1], req[2]};
	assign f_word2  = {req[3], req[4]};
	assign cur_addr = f_addr + {11'h000, k};
	assign pos      = base + {k[4:0], 1'b0};
	// group in the high byte, index inside the group in the low byte
	assign addr_ok  = (cur_addr[15:8] < fieldbus_pkg::NUM_GROUPS) &&
	                  (cur_addr[7:0] < fieldbus_pkg::GROUP_SIZE);
	assign wr_en    = (state == fieldbus_pkg::ST_WRITE);
	assign wr.idx   = {cur_addr[8 +: fieldbus_pkg::GRP_W],
	                   cur_addr[0 +: fieldbus_pkg::IDX_W]};
	assign wr.data  = {req[pos], req[pos + 6'h01]};
	assign wr.save  = save;

	param_store #(
		.LOCK_MAP    (LOCK_MAP),
		.NV_CYC      (NV_CYC)
	) store (
		.i_sys_clk   (i_sys_clk),
		.i_sys_rst   (i_sys_rst),
		.i_wr_en     (wr_en),
		.i_wr        (wr),
		.i_lock_idx  (wr.idx),
		.o_locked    (st_locked),
		.i_app_idx   (i_app_idx),
		.o_app_value (o_app_value),
		.o_busy      (st_busy),
		.o_ready     (st_ready)
	);

	// -----------------------------------------------------------------
	// next-state logic
	// -----------------------------------------------------------------
	always_comb begin
		next_state    = state;
		next_req      = req;
		next_resp     = resp;
		next_cnt      = cnt;
		next_ovf      = ovf;
		next_resp_len = resp_len;
		next_tx_ptr   = tx_ptr;
		next_err_fn   = err_fn;
		next_num      = num;
		next_k        = k;
		next_base     = base;
		next_save     = save;
		next_tx_valid = o_tx_valid;
		next_tx_data  = o_tx_data;
		next_tx_last  = o_tx_last;
		// normal answers of all three kinds are the first five bytes
		for (int i = 0; i < fieldbus_pkg::RESP_BYTES; i++)
			next_resp[i] = req[i];
		if (state != fieldbus_pkg::ST_EXEC && state != fieldbus_pkg::ST_CHECK)
			next_resp = resp;
		case (state)
		fieldbus_pkg::ST_IDLE: begin
			if (i_rx_valid) begin
				if (cnt < fieldbus_pkg::REQ_MAX) begin
					next_req[cnt] = i_rx_data;
					next_cnt      = cnt + 6'h01;
				end else begin
					next_ovf = 1'b1;
				end
				if (i_rx_last)
					next_state = fieldbus_pkg::ST_EXEC;
			end
		end
		fieldbus_pkg::ST_EXEC: begin
			next_resp_len = fieldbus_pkg::LEN_NORMAL;
			next_k        = 5'h00;
			next_state    = fieldbus_pkg::ST_CHECK;
			next_num      = 5'h01;
			next_base     = fieldbus_pkg::BASE_SINGLE;
			next_save     = 1'b0;
			next_resp_len = fieldbus_pkg::LEN_EXC;
			next_resp[1]  = fieldbus_pkg::EXC_ILL_VALUE;
			case (req[0])
			fieldbus_pkg::FN_DIAG: begin
				next_resp[0] = fieldbus_pkg::FN_DIAG_ERR;
				next_state   = fieldbus_pkg::ST_TX;
				if (!ovf && cnt == fieldbus_pkg::LEN_SINGLE) begin
					if (f_addr == fieldbus_pkg::SUB_ECHO) begin
						next_resp     = req[0:4];
						next_resp_len = fieldbus_pkg::LEN_NORMAL;
					end else begin
						next_resp[1] = fieldbus_pkg::EXC_ILL_FN;
					end
				end
			end
			fieldbus_pkg::FN_WR_SAVE, fieldbus_pkg::FN_WR_RAM: begin
				next_save   = (req[0] == fieldbus_pkg::FN_WR_SAVE);
				next_err_fn = next_save ? fieldbus_pkg::FN_WR_SAVE_ERR :
				              fieldbus_pkg::FN_WR_RAM_ERR;
				next_resp[0] = next_err_fn;
				if (ovf || cnt != fieldbus_pkg::LEN_SINGLE)
					next_state = fieldbus_pkg::ST_TX;
			end
			fieldbus_pkg::FN_WR_MULTI: begin
				next_err_fn  = fieldbus_pkg::FN_WR_MULTI_ERR;
				next_resp[0] = fieldbus_pkg::FN_WR_MULTI_ERR;
				next_num     = f_word2[4:0];
				next_base    = fieldbus_pkg::BASE_MULTI;
				if (ovf || f_word2 == 16'h0000 ||
				    f_word2 > fieldbus_pkg::MAX_REGS ||
				    req[5] != {2'b00, f_word2[4:0], 1'b0} ||
				    cnt != fieldbus_pkg::LEN_MULTI_HDR + req[5][5:0])
					next_state = fieldbus_pkg::ST_TX;
			end
			default: begin
				next_resp[0] = req[0] | fieldbus_pkg::FN_ERR_FLAG;
				next_resp[1] = fieldbus_pkg::EXC_ILL_FN;
				next_state   = fieldbus_pkg::ST_TX;
			end
			endcase
			// a frame that goes on to the checks keeps its echo bytes
			if (next_state == fieldbus_pkg::ST_CHECK) begin
				next_resp_len = fieldbus_pkg::LEN_NORMAL;
				next_resp[0]  = req[0];
				next_resp[1]  = req[1];
			end
		end
		fieldbus_pkg::ST_CHECK: begin
			// every target is checked before the first word is written
			if (st_ready && !st_busy) begin
				next_resp_len = fieldbus_pkg::LEN_EXC;
				next_resp[0]  = err_fn;
				next_state    = fieldbus_pkg::ST_TX;
				if (!addr_ok) begin
					next_resp[1] = fieldbus_pkg::EXC_ILL_ADDR;
				end else if (st_locked && i_running) begin
					next_resp[1] = fieldbus_pkg::EXC_LOCKED;
				end else begin
					next_resp     = resp;
					next_resp_len = resp_len;
					next_state    = fieldbus_pkg::ST_CHECK;
					next_k        = k + 5'h01;
					if (k == num - 5'h01) begin
						next_k     = 5'h00;
						next_state = fieldbus_pkg::ST_WRITE;
					end
				end
			end else begin
				next_resp = resp;
			end
		end
		fieldbus_pkg::ST_WRITE: begin
			if (save) begin
				next_state = fieldbus_pkg::ST_WAIT;
			end else if (k == num - 5'h01) begin
				next_state = fieldbus_pkg::ST_TX;
			end else begin
				next_k = k + 5'h01;
			end
		end
		fieldbus_pkg::ST_WAIT: begin
			if (!st_busy)
				next_state = fieldbus_pkg::ST_TX;
		end
		fieldbus_pkg::ST_TX: begin
			if (!o_tx_valid) begin
				next_tx_valid = 1'b1;
				next_tx_data  = resp[tx_ptr];
				next_tx_last  = (tx_ptr == resp_len - 3'h1);
			end else if (i_tx_ready) begin
				if (o_tx_last) begin
					next_tx_valid = 1'b0;
					next_tx_last  = 1'b0;
					next_tx_ptr   = 3'h0;
					next_cnt      = 6'h00;
					next_ovf      = 1'b0;
					next_state    = fieldbus_pkg::ST_IDLE;
				end else begin
					next_tx_ptr  = tx_ptr + 3'h1;
					next_tx_data = resp[tx_ptr + 3'h1];
					next_tx_last = (tx_ptr + 3'h1 == resp_len - 3'h1);
				end
			end
		end
		default: begin
			next_state = fieldbus_pkg::ST_IDLE;
		end
		endcase
		next_rx_ready = (next_state == fieldbus_pkg::ST_IDLE);
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state      <= fieldbus_pkg::ST_IDLE;
			req        <= '{default: 8'h00};
			resp       <= '{default: 8'h00};
			cnt        <= 6'h00;
			ovf        <= 1'b0;
			resp_len   <= 3'h0;
			tx_ptr     <= 3'h0;
			err_fn     <= 8'h00;
			num        <= 5'h00;
			k          <= 5'h00;
			base       <= 6'h00;
			save       <= 1'b0;
			o_rx_ready <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_data  <= 8'h00;
			o_tx_last  <= 1'b0;
		end else begin
			state      <= next_state;
			req        <= next_req;
			resp       <= next_resp;
			cnt        <= next_cnt;
			ovf        <= next_ovf;
			resp_len   <= next_resp_len;
			tx_ptr     <= next_tx_ptr;
			err_fn     <= next_err_fn;
			num        <= next_num;
			k          <= next_k;
			base       <= next_base;
			save       <= next_save;
			o_rx_ready <= next_rx_ready;
			o_tx_valid <= next_tx_valid;
			o_tx_data  <= next_tx_data;
			o_tx_last  <= next_tx_last;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	locked_reject_a: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst)
		(state == fieldbus_pkg::ST_CHECK && st_ready && !st_busy &&
		 err_fn == fieldbus_pkg::FN_WR_MULTI_ERR && addr_ok &&
		 st_locked && i_running) |=>
		(resp[0] == 8'hc2 && resp[1] == 8'h01 && resp_len == 3'h2 &&
		 state == fieldbus_pkg::ST_TX))
		else $error("locked multi write not refused");

	diag_length_a: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst)
		(state == fieldbus_pkg::ST_EXEC && req[0] == 8'h08 &&
		 cnt != 6'h05) |=> (resp[0] == 8'h88 && resp[1] == 8'h03))
		else $error("short diagnosis frame accepted");

	diag_echo_a: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst)
		(state == fieldbus_pkg::ST_EXEC && req[0] == 8'h08 && !ovf &&
		 cnt == 6'h05 && f_addr == 16'h0000) |=>
		(resp[0] == req[0] && resp[1] == req[1] && resp[2] == req[2] &&
		 resp[3] == req[3] && resp[4] == req[4] && resp_len == 3'h5) ##1
		(o_tx_valid && o_tx_data == 8'h08))
		else $error("echo differs from request");

	diag_order_a: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst)
		(o_tx_valid && resp[0] == 8'h08 && resp_len == 3'h5) |->
		(o_tx_data == resp[tx_ptr] && o_tx_last == (tx_ptr == 3'h4)))
		else $error("diagnosis reply out of order");

	diag_no_write_a: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst)
		wr_en |-> (req[0] != 8'h08))
		else $error("diagnosis touched a parameter");

	diag_fail_a: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst)
		(state == fieldbus_pkg::ST_EXEC && req[0] == 8'h08 && !ovf &&
		 cnt == 6'h05 && f_addr != 16'h0000) |=>
		(resp[0] == 8'h88 && resp[1] == 8'h01 && resp_len == 3'h2))
		else $error("bad sub-function not refused");

	save_write_a: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst)
		(wr_en && req[0] == 8'h06) |->
		(wr.save && wr.data == {req[3], req[4]}))
		else $error("saved write lost its value");

	reply_after_save_a: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst)
		(o_tx_valid && resp[0] == 8'h06 && resp_len == 3'h5) |-> !st_busy)
		else $error("reply sent before save ended");

	ram_only_a: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst)
		(wr_en && req[0] != 8'h06) |-> !wr.save)
		else $error("ram-only write reached storage");

	count_range_a: assert property (@(posedge i_sys_clk)
		disable iff (i_sys_rst)
		(state == fieldbus_pkg::ST_EXEC && req[0] == 8'h42 &&
		 (f_word2 == 16'h0000 || f_word2 > 16'h0010)) |=>
		(resp[0] == 8'hc2 && resp[1] == 8'h03))
		else $error("bad register count accepted");
endmodule // fieldbus_handler

`default_nettype wire

//--- verification/tx_sink_model.sv
// response sink standing in for the master station that reads replies
// assumes the bench seeds $urandom; ready moves on falling edges only
`default_nettype none

module tx_sink_model (
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_sys_rst,
	// response handshake
	output logic      o_tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	// -----------------------------------------------------------------
	// random stalls
	// -----------------------------------------------------------------
	// a quarter of the cycles stall, so each byte must stand until taken
	always @(negedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_tx_ready <= 1'b0;
		else
			o_tx_ready <= ($urandom_range(3) != 0);
	end
endmodule // tx_sink_model

`default_nettype wire

//--- verification/test_modbus_slave_write_diag_handler.sv
// self-checking bench for the fieldbus write and diagnosis handler
// assumes the handler package is compiled first and the sink model beside
`default_nettype none

module test_modbus_slave_write_diag_handler;
	timeunit 1ns;
	timeprecision 1ps;

	// -----------------------------------------------------------------
	// signals
	// -----------------------------------------------------------------
	localparam int NV = 12;
	logic                              i_sys_clk;
	logic                              i_sys_rst;
	logic                              i_rx_valid;
	logic [7:0]                        i_rx_data;
	logic                              i_rx_last;
	logic                              o_rx_ready;
	logic                              o_tx_valid;
	logic [7:0]                        o_tx_data;
	logic                              o_tx_last;
	logic                              i_tx_ready;
	logic                              i_running;
	logic [fieldbus_pkg::PIDX_W-1:0]   i_app_idx;
	logic [15:0]                       o_app_value;
	int                                n_errors = 0;
	int                                n_tests = 0;
	int                                lat = 0;
	int                                resp_lat = 0;
	logic                              seen = 1'b1;
	logic [8:0]                        exp_q[$];
	logic [8:0]                        got;
	logic [15:0]                       d;
	logic [15:0]                       v6;
	logic [15:0]                       v4;
	logic [7:0]                        mq[$];

	initial i_sys_clk = 1'b0;
	always #12.5 i_sys_clk = ~i_sys_clk;

	// index 5 is the one parameter locked while running
	fieldbus_handler #(.LOCK_MAP(128'h20), .NV_CYC(NV)) uut (
		.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
		.i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
		.i_rx_last(i_rx_last), .o_rx_ready(o_rx_ready),
		.o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
		.o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready),
		.i_running(i_running), .i_app_idx(i_app_idx),
		.o_app_value(o_app_value));
	tx_sink_model sink (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
		.o_tx_ready(i_tx_ready));

	// -----------------------------------------------------------------
	// reporting
	// -----------------------------------------------------------------
	task automatic fail(input string m);
		n_errors++;
		$display("mismatch at %0t: %s", $time, m);
	endtask

	task automatic complete_run();
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// response monitor and latency from last request byte
	// -----------------------------------------------------------------
	always @(posedge i_sys_clk) begin
		if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
			n_tests++;
			if (exp_q.size() == 0) begin
				fail("unexpected response byte");
			end else begin
				got = exp_q.pop_front();
				if ({o_tx_last, o_tx_data} !== got)
					fail("response byte");
			end
		end
		if (i_rx_valid && i_rx_last && o_rx_ready === 1'b1) begin
			lat <= 0;
			seen <= 1'b0;
		end else begin
			lat <= lat + 1;
			if (o_tx_valid === 1'b1 && !seen) begin
				seen <= 1'b1;
				resp_lat <= lat;
			end
		end
	end

	// -----------------------------------------------------------------
	// drivers: called on a falling edge with the handler idle
	// -----------------------------------------------------------------
	task automatic xfer(input logic [7:0] rq[$], input logic [7:0] rs[$]);
		int w;
		foreach (rs[j]) exp_q.push_back({1'(j == rs.size() - 1), rs[j]});
		foreach (rq[k]) begin
			i_rx_valid <= 1'b1;
			i_rx_data <= rq[k];
			i_rx_last <= (k == rq.size() - 1);
			@(negedge i_sys_clk);
		end
		i_rx_valid <= 1'b0;
		i_rx_last <= 1'b0;
		w = 0;
		while ((o_rx_ready !== 1'b1 || exp_q.size() != 0) && w < 600) begin
			@(negedge i_sys_clk);
			w++;
		end
		if (w >= 600) begin
			fail("response timeout");
			complete_run();
		end
	endtask

	// five-byte request; code 0 expects the echo, else {fn|80, code}
	task automatic single(input logic [7:0] fn, input logic [15:0] a,
			input logic [15:0] v, input logic [7:0] e);
		if (e == 8'h00)
			xfer('{fn, a[15:8], a[7:0], v[15:8], v[7:0]},
				'{fn, a[15:8], a[7:0], v[15:8], v[7:0]});
		else
			xfer('{fn, a[15:8], a[7:0], v[15:8], v[7:0]}, '{fn | 8'h80, e});
	endtask

	task automatic chk(input logic [fieldbus_pkg::PIDX_W-1:0] ix,
			input logic [15:0] v);
		i_app_idx <= ix;
		@(negedge i_sys_clk);
		@(negedge i_sys_clk);
		n_tests++;
		if (o_app_value !== v)
			fail("application value");
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	initial begin
		void'($urandom(77));
		{i_sys_rst, i_rx_valid, i_rx_data, i_rx_last} = 11'h400;
		i_running = 1'b0;
		i_app_idx = '0;
		repeat (4) @(negedge i_sys_clk);
		i_sys_rst = 1'b0;
		@(negedge i_sys_clk);
		d = 16'($urandom);
		single(8'h08, 16'h0000, 16'ha537, 8'h00);
		single(8'h08, 16'h0000, d, 8'h00);
		single(8'h08, 16'h0001, d, 8'h01);
		xfer('{8'h08, 8'h00, 8'h00, 8'ha5}, '{8'h88, 8'h03});
		single(8'h03, 16'h0001, d, 8'h01);
		v6 = 16'($urandom);
		single(8'h06, 16'h0001, v6, 8'h00);
		n_tests++;
		if (resp_lat < NV) fail("echo before save");
		chk(7'h01, v6);
		// frequent changes go through the ram-only write
		for (int i = 0; i < 3; i++) begin
			single(8'h41, 16'h0001, v6 ^ 16'(i + 1), 8'h00);
			n_tests++;
			if (resp_lat >= NV) fail("ram write waited");
			chk(7'h01, v6 ^ 16'(i + 1));
		end
		single(8'h41, 16'h0305, d, 8'h00);
		chk(7'h35, d);
		single(8'h41, 16'h0800, d, 8'h02);
		xfer('{8'h42, 8'h00, 8'h0e, 8'h00, 8'h02, 8'h04, 8'h01, 8'hf4,
			8'h02, 8'h58}, '{8'h42, 8'h00, 8'h0e, 8'h00, 8'h02});
		chk(7'h0e, 16'h01f4);
		chk(7'h0f, 16'h0258);
		mq = '{8'h42, 8'h01, 8'h00, 8'h00, 8'h10, 8'h20};
		for (int i = 0; i < 16; i++) begin
			mq.push_back(8'(i));
			mq.push_back(d[7:0]);
		end
		xfer(mq, '{8'h42, 8'h01, 8'h00, 8'h00, 8'h10});
		chk(7'h1f, {8'h0f, d[7:0]});
		mq[4] = 8'h11;
		mq[5] = 8'h22;
		mq.push_back(8'h77);
		mq.push_back(8'h77);
		xfer(mq, '{8'hc2, 8'h03});
		chk(7'h10, {8'h00, d[7:0]});
		v4 = 16'($urandom);
		single(8'h41, 16'h0004, v4, 8'h00);
		i_running = 1'b1;
		xfer('{8'h42, 8'h00, 8'h04, 8'h00, 8'h02, 8'h04, 8'h11, 8'h11,
			8'h22, 8'h22}, '{8'hc2, 8'h01});
		chk(7'h04, v4);
		single(8'h06, 16'h0005, d, 8'h01);
		single(8'h08, 16'h0000, 16'h0004, 8'h00);
		chk(7'h04, v4);
		i_running = 1'b0;
		// power cycle: ram-only values drop, the saved one returns
		i_sys_rst = 1'b1;
		repeat (4) @(negedge i_sys_clk);
		i_sys_rst = 1'b0;
		@(negedge i_sys_clk);
		single(8'h41, 16'h0002, d, 8'h00);
		chk(7'h01, v6);
		complete_run();
	end
endmodule // test_modbus_slave_write_diag_handler

`default_nettype wire
